// [src/wse_top.sv]
// Wake-event status, enable and wake-output logic with its register bus.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "wse_map.svh"

// What this block does
// R1 - A status bit sets when its source signals and holds until cleared.
// R2 - Status records events regardless of any enable bit.
// R3 - A register write clears each status bit 7 to 0 whose data bit is one.
// R4 - Writing zero to a status bit leaves it unchanged.
// R5 - Status survives the other resets; only the standby reset clears 08.
// R6 - Pins fifty to fifty-seven map to bits 0 to 7 of status register 08.
// R7 - Register 09 holds the eight peripheral events in a fixed order.
// R8 - Every reset forces bit 0 of register 09 to one; it resets to 0x01.
// R9 - The parallel source is one while the parallel port is not activated.
// R10 - The parallel source follows printer acknowledge while activated.
// R11 - Wake asserts when a source has enable, status and global enable set.
// R12 - A disabled source still records status but never drives wake.
// R13 - Register 0A bits 0 to 6 enable the seven misc sources in fixed order.
// R14 - Enable registers survive main-supply, soft and bus resets.
// R15 - Wake is active low, ORs enabled set bits and releases when they clear.
// R16 - The listed resets force bit 0 of register 09 and keep all else.
module wse_top (
    // Clock and standby-power reset
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    // Resets that the stored state survives
    input  wire logic        MAIN_POR,
    input  wire logic        SOFT_RST,
    input  wire logic        BUS_RST,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O,
    // General-purpose wake pins
    input  wire logic [7:0]  GPIO_WAKE,
    // Peripheral events
    input  wire logic        PAR_ACTIVATE,
    input  wire logic        PRINTER_ACKNOWLEDGE_N,
    input  wire logic        SERIAL_TWO_IRQ,
    input  wire logic        SERIAL_ONE_IRQ,
    input  wire logic        FLOPPY_IRQ,
    input  wire logic        MOUSE_IRQ,
    input  wire logic        KEYBOARD_IRQ,
    input  wire logic        WATCHDOG_EVENT,
    input  wire logic        SYSTEM_MGMT_BUS_EVENT,
    // Sources gated by the first enable register
    input  wire logic        KBC_PORT_BIT_TWELVE,
    input  wire logic        KBC_PORT_BIT_SIXTEEN,
    input  wire logic        RING_INDICATE_ONE_N,
    input  wire logic        KEYBOARD_WAKE,
    input  wire logic        MOUSE_WAKE,
    input  wire logic        SPECIFIC_KEY_WAKE,
    input  wire logic        FAN_SPEED_PULSE,
    // Wake control and outputs
    input  wire logic        GLOBAL_WAKE_ENABLE,
    output logic             WAKE_OUT_N,
    output logic             WAKE_IRQ
);
    import wse_pkg::*;

    wse_top_st_t  st_reg;
    wse_top_st_t  st_next;
    wse_bus_req_t bus_req;
    wse_reg_acc_t acc;
    logic         parallel_irq_src;
    logic         sync_rst;
    logic [7:0]   gpio_set;
    logic [7:0]   peri_set;
    logic [7:0]   misc_set;
    logic [7:0]   gpio_clr;
    logic [7:0]   peri_clr;
    logic [7:0]   misc_clr;
    logic [7:0]   peri_force;
    logic [7:0]   gpio_sts;
    logic [7:0]   peri_sts;
    logic [7:0]   misc_sts;
    logic         pend;

    assign bus_req.cyc  = WB_CYC_I;
    assign bus_req.stb  = WB_STB_I;
    assign bus_req.we   = WB_WE_I;
    assign bus_req.sel0 = WB_SEL_I[0];
    assign bus_req.idx  = WB_ADR_I[7:2];
    assign bus_req.dat  = WB_DAT_I[7:0];

    wse_wb_slave u_slave (
        .clk (CORE_CLK),
        .rst (RESET),
        .req (bus_req),
        .ack (WB_ACK_O),
        .acc (acc)
    );

    // The other resets are plain synchronous inputs; only RESET clears.
    assign sync_rst = MAIN_POR || SOFT_RST || BUS_RST; // [R5]

    // Held high while idle, so a disabled port keeps its bit set.
    assign parallel_irq_src = PAR_ACTIVATE ? PRINTER_ACKNOWLEDGE_N // [R10]
                                           : 1'b1;                 // [R9]

    assign gpio_set = GPIO_WAKE; // [R6]

    always_comb begin
        peri_set                  = '0;
        peri_set[`WSE_PERI_PAR]   = parallel_irq_src;      // [R7]
        peri_set[`WSE_PERI_SER2]  = SERIAL_TWO_IRQ;        // [R7]
        peri_set[`WSE_PERI_SER1]  = SERIAL_ONE_IRQ;
        peri_set[`WSE_PERI_FLOP]  = FLOPPY_IRQ;
        peri_set[`WSE_PERI_MOUSE] = MOUSE_IRQ;
        peri_set[`WSE_PERI_KEYB]  = KEYBOARD_IRQ;
        peri_set[`WSE_PERI_WDOG]  = WATCHDOG_EVENT;
        peri_set[`WSE_PERI_MGMT]  = SYSTEM_MGMT_BUS_EVENT;
        misc_set                  = '0;
        misc_set[`WSE_EN_KBC12]   = KBC_PORT_BIT_TWELVE;   // [R13]
        misc_set[`WSE_EN_KBC16]   = KBC_PORT_BIT_SIXTEEN;  // [R13]
        misc_set[`WSE_EN_RING]    = !RING_INDICATE_ONE_N;
        misc_set[`WSE_EN_KEYB]    = KEYBOARD_WAKE;
        misc_set[`WSE_EN_MOUSE]   = MOUSE_WAKE;
        misc_set[`WSE_EN_SPKEY]   = SPECIFIC_KEY_WAKE;
        misc_set[`WSE_EN_FAN]     = FAN_SPEED_PULSE;
        peri_force                = '0;
        peri_force[`WSE_PERI_PAR] = sync_rst;              // [R8] [R16]
    end

    // Clears come from the written data; zero bits clear nothing.
    always_comb begin
        gpio_clr = '0;
        peri_clr = '0;
        misc_clr = '0;
        if (acc.wr && acc.idx == `WSE_IDX_GPIO_STS) begin
            gpio_clr = acc.dat; // [R3] [R4]
        end
        if (acc.wr && acc.idx == `WSE_IDX_PERI_STS) begin
            peri_clr = acc.dat; // [R3] [R4]
        end
        if (acc.wr && acc.idx == `WSE_IDX_MISC_STS) begin
            misc_clr = acc.dat;
        end
    end

    // Status sees no enable, so it records whatever the gating. [R2]
    wse_event_latch #(.RST_VALUE(`WSE_RST_GPIO_STS)) u_gpio_sts (
        .clk      (CORE_CLK),
        .rst      (RESET),
        .set_in   (gpio_set),
        .clr_in   (gpio_clr),
        .force_in (8'h00),
        .q        (gpio_sts)
    );

    wse_event_latch #(.RST_VALUE(`WSE_RST_PERI_STS)) u_peri_sts (
        .clk      (CORE_CLK),
        .rst      (RESET),
        .set_in   (peri_set),
        .clr_in   (peri_clr),
        .force_in (peri_force),
        .q        (peri_sts)
    );

    wse_event_latch #(.RST_VALUE(`WSE_RST_MISC_STS)) u_misc_sts (
        .clk      (CORE_CLK),
        .rst      (RESET),
        .set_in   (misc_set),
        .clr_in   (misc_clr),
        .force_in (8'h00),
        .q        (misc_sts)
    );

    // A disabled source is masked here and nowhere else. [R12]
    assign pend = |(gpio_sts & st_reg.gpio_en) ||
                  |(peri_sts & st_reg.peri_en) ||
                  |(misc_sts[6:0] & st_reg.en_first); // [R11] [R13]

    always_comb begin
        st_next        = st_reg;
        st_next.irq    = pend;
        st_next.wake_n = !(pend && GLOBAL_WAKE_ENABLE); // [R11] [R15]
        // Enables take no part in sync_rst, so they ride through it.
        if (acc.wr) begin // [R14]
            case (acc.idx)
                `WSE_IDX_EN_FIRST: begin
                    st_next.en_first = acc.dat[6:0];
                end
                `WSE_IDX_GPIO_EN: begin
                    st_next.gpio_en = acc.dat;
                end
                `WSE_IDX_PERI_EN: begin
                    st_next.peri_en = acc.dat;
                end
                default: begin
                    st_next.en_first = st_reg.en_first;
                end
            endcase
        end
        if (acc.rd) begin
            case (acc.idx)
                `WSE_IDX_GPIO_STS: st_next.rdata = gpio_sts;
                `WSE_IDX_PERI_STS: st_next.rdata = peri_sts;
                `WSE_IDX_EN_FIRST: st_next.rdata = {1'b0, st_reg.en_first};
                `WSE_IDX_MISC_STS: st_next.rdata = {1'b0, misc_sts[6:0]};
                `WSE_IDX_GPIO_EN:  st_next.rdata = st_reg.gpio_en;
                `WSE_IDX_PERI_EN:  st_next.rdata = st_reg.peri_en;
                default:           st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            st_reg.gpio_en  <= `WSE_RST_ENABLE;
            st_reg.peri_en  <= `WSE_RST_ENABLE;
            st_reg.en_first <= 7'h00;
            st_reg.rdata    <= 8'h00;
            st_reg.wake_n   <= 1'b1;
            st_reg.irq      <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign WB_DAT_O   = {24'h000000, st_reg.rdata};
    assign WAKE_OUT_N = st_reg.wake_n;
    assign WAKE_IRQ   = st_reg.irq;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);

    gpio_set_a: assert property ( // [R1]
        gpio_set != 8'h00 |=> (gpio_sts & $past(gpio_set)) == $past(gpio_set))
        else $error("gpio event not latched");

    status_hold_a: assert property ( // [R4]
        1'b1 |=> (gpio_sts & $past(gpio_sts & ~gpio_clr))
                 == $past(gpio_sts & ~gpio_clr))
        else $error("status bit lost without a clear");

    w1c_clear_a: assert property ( // [R3]
        acc.wr && acc.idx == `WSE_IDX_PERI_STS |=>
        (peri_sts & $past(peri_clr & ~peri_set & ~peri_force)) == 8'h00)
        else $error("written one did not clear status");

    enable_indep_a: assert property ( // [R2]
        peri_set != 8'h00 && st_reg.peri_en == 8'h00 && !GLOBAL_WAKE_ENABLE
        |=> (peri_sts & $past(peri_set)) == $past(peri_set))
        else $error("disabled source not recorded");

    masked_quiet_a: assert property ( // [R12]
        st_reg.gpio_en == 8'h00 && st_reg.peri_en == 8'h00 &&
        st_reg.en_first == 7'h00 && !acc.wr ##1 !acc.wr |=> WAKE_OUT_N)
        else $error("disabled source drove wake");

    wake_assert_a: assert property ( // [R11]
        pend && GLOBAL_WAKE_ENABLE |=> !WAKE_OUT_N && WAKE_IRQ)
        else $error("wake not asserted");

    wake_release_a: assert property ( // [R15]
        !(pend && GLOBAL_WAKE_ENABLE) |=> WAKE_OUT_N)
        else $error("wake not released");

    ring_wake_a: assert property ( // [R13]
        !RING_INDICATE_ONE_N && st_reg.en_first[`WSE_EN_RING] &&
        GLOBAL_WAKE_ENABLE && !acc.wr ##1 GLOBAL_WAKE_ENABLE && !acc.wr
        |=> !WAKE_OUT_N)
        else $error("ring wake not seen on output");

    par_idle_a: assert property ( // [R9]
        !PAR_ACTIVATE |=> peri_sts[`WSE_PERI_PAR])
        else $error("idle parallel source not one");

    par_follow_a: assert property ( // [R10]
        PAR_ACTIVATE && PRINTER_ACKNOWLEDGE_N |=> peri_sts[`WSE_PERI_PAR])
        else $error("parallel source ignored acknowledge");

    soft_reset_a: assert property ( // [R8]
        sync_rst |=> peri_sts[`WSE_PERI_PAR] &&
        (gpio_sts | $past(gpio_clr)) == ($past(gpio_sts) | $past(gpio_set) |
                                          $past(gpio_clr)))
        else $error("reset handling of status wrong");

    enable_keep_a: assert property ( // [R14]
        sync_rst && !acc.wr |=> st_reg.en_first == $past(st_reg.en_first) &&
        st_reg.gpio_en == $past(st_reg.gpio_en))
        else $error("enable lost on soft reset");

    ack_pulse_a: assert property (
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("ack not a single pulse");

    wake_seen_c: cover property (!WAKE_OUT_N);
    clear_seen_c: cover property (
        acc.wr && acc.idx == `WSE_IDX_GPIO_STS && gpio_clr != 8'h00);
    reset_seen_c: cover property (sync_rst ##1 peri_sts[`WSE_PERI_PAR]);
    release_c: cover property (!WAKE_OUT_N ##[1:20] WAKE_OUT_N);
endmodule : wse_top

// [src/wse_map.svh]
// Register indices, reset values and bit positions of the wake block.
`ifndef WSE_MAP_SVH
`define WSE_MAP_SVH

`define WSE_IDX_GPIO_STS 6'h08
`define WSE_IDX_PERI_STS 6'h09
`define WSE_IDX_EN_FIRST 6'h0a
`define WSE_IDX_MISC_STS 6'h10
`define WSE_IDX_GPIO_EN  6'h11
`define WSE_IDX_PERI_EN  6'h12

`define WSE_RST_GPIO_STS 8'h00
`define WSE_RST_PERI_STS 8'h01
`define WSE_RST_MISC_STS 8'h00
`define WSE_RST_ENABLE   8'h00

`define WSE_PERI_PAR   0
`define WSE_PERI_SER2  1
`define WSE_PERI_SER1  2
`define WSE_PERI_FLOP  3
`define WSE_PERI_MOUSE 4
`define WSE_PERI_KEYB  5
`define WSE_PERI_WDOG  6
`define WSE_PERI_MGMT  7

`define WSE_EN_KBC12   0
`define WSE_EN_KBC16   1
`define WSE_EN_RING    2
`define WSE_EN_KEYB    3
`define WSE_EN_MOUSE   4
`define WSE_EN_SPKEY   5
`define WSE_EN_FAN     6
`define WSE_EN_FIRST_W 7

`endif

// [src/wse_pkg.sv]
// Types shared by the wake-event status and enable block.
package wse_pkg;
    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic       sel0;
        logic [5:0] idx;
        logic [7:0] dat;
    } wse_bus_req_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] idx;
        logic [7:0] dat;
    } wse_reg_acc_t;

    typedef struct packed {
        logic ack;
    } wse_slave_st_t;

    typedef struct packed {
        logic [7:0] bits;
    } wse_latch_st_t;

    typedef struct packed {
        logic [7:0] gpio_en;
        logic [7:0] peri_en;
        logic [6:0] en_first;
        logic [7:0] rdata;
        logic       wake_n;
        logic       irq;
    } wse_top_st_t;
endpackage : wse_pkg

// [src/wse_wb_slave.sv]
// Classic Wishbone slave handshake: one wait state, then a one-cycle ack.
`timescale 1ns/1ps
module wse_wb_slave (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Bus side
    input  wire wse_pkg::wse_bus_req_t req,
    output logic                       ack,
    // Register side
    output wse_pkg::wse_reg_acc_t      acc
);
    import wse_pkg::*;

    wse_slave_st_t st_reg;
    wse_slave_st_t st_next;

    // Ack drops after one cycle, so a held request is taken again every second cycle.
    always_comb begin
        st_next     = st_reg;
        st_next.ack = req.cyc && req.stb && !st_reg.ack;
        acc.wr      = req.cyc && req.stb && req.we && req.sel0 && st_reg.ack;
        acc.rd      = req.cyc && req.stb && !req.we && !st_reg.ack;
        acc.idx     = req.idx;
        acc.dat     = req.dat;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ack = st_reg.ack;
endmodule : wse_wb_slave

// [src/wse_event_latch.sv]
// Eight sticky event bits with write-one-to-clear and a forced-set input.
`timescale 1ns/1ps
module wse_event_latch #(
    parameter logic [7:0] RST_VALUE = 8'h00
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Events and clears
    input  wire logic [7:0] set_in,
    input  wire logic [7:0] clr_in,
    input  wire logic [7:0] force_in,
    // Stored bits
    output logic [7:0]      q
);
    import wse_pkg::*;

    wse_latch_st_t st_reg;
    wse_latch_st_t st_next;
    logic [7:0]    bit_next;

    // A set in the clear cycle wins, so no event is lost to a slow clear.
    for (genvar i = 0; i < 8; i++) begin : g_bit
        assign bit_next[i] = set_in[i] || force_in[i] || // [R1]
                             (st_reg.bits[i] && !clr_in[i]);
    end

    always_comb begin
        st_next      = st_reg;
        st_next.bits = bit_next;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg.bits <= RST_VALUE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.bits;
endmodule : wse_event_latch

// [test/wse_wake_host.sv]
// Model of the system wake logic that watches the wake output.
`timescale 1ns/1ps
module wse_wake_host (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    // Wake line from the block
    input  wire logic  wake_n,
    // Number of wake requests seen
    output logic [7:0] wake_count
);
    logic prev_n;

    // A held level counts once, so a stuck wake line shows as one request.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_n     <= 1'b1;
            wake_count <= 8'h00;
        end else begin
            prev_n <= wake_n;
            if (prev_n && !wake_n) begin
                wake_count <= wake_count + 8'h01;
            end
        end
    end
endmodule : wse_wake_host

// [test/wse_top_tb.sv]
// Self-checking testbench of the wake-event status and enable block.
`timescale 1ns/1ps
module wse_top_tb;
    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic [2:0]  rsts      = 3'h0;
    logic        cyc       = 1'b0;
    logic        stb       = 1'b0;
    logic        we        = 1'b0;
    logic [7:0]  adr       = 8'h00;
    logic [31:0] wdat      = 32'h00000000;
    logic [7:0]  gpio      = 8'h00;
    logic        par_act   = 1'b1;
    logic        prn_ack_n = 1'b0;
    logic [7:0]  peri      = 8'h00;
    logic [6:0]  misc      = 7'h00;
    logic        glob      = 1'b0;
    logic [31:0] rdat;
    logic        ack;
    logic        wake_n;
    logic        irq;
    logic [7:0]  wakes;
    int          bad_count = 0;
    int          checked   = 0;

    wse_top dut (
        .CORE_CLK(clk), .RESET(rst),
        .MAIN_POR(rsts[0]), .SOFT_RST(rsts[1]), .BUS_RST(rsts[2]),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .GPIO_WAKE(gpio), .PAR_ACTIVATE(par_act),
        .PRINTER_ACKNOWLEDGE_N(prn_ack_n),
        .SERIAL_TWO_IRQ(peri[1]), .SERIAL_ONE_IRQ(peri[2]),
        .FLOPPY_IRQ(peri[3]), .MOUSE_IRQ(peri[4]), .KEYBOARD_IRQ(peri[5]),
        .WATCHDOG_EVENT(peri[6]), .SYSTEM_MGMT_BUS_EVENT(peri[7]),
        .KBC_PORT_BIT_TWELVE(misc[0]), .KBC_PORT_BIT_SIXTEEN(misc[1]),
        .RING_INDICATE_ONE_N(~misc[2]), .KEYBOARD_WAKE(misc[3]),
        .MOUSE_WAKE(misc[4]), .SPECIFIC_KEY_WAKE(misc[5]),
        .FAN_SPEED_PULSE(misc[6]), .GLOBAL_WAKE_ENABLE(glob),
        .WAKE_OUT_N(wake_n), .WAKE_IRQ(irq)
    );

    wse_wake_host host (
        .clk(clk), .rst(rst), .wake_n(wake_n), .wake_count(wakes)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic finish_test;
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // The request is held until the edge that samples ack, then dropped.
    task automatic wb(input logic w, input logic [5:0] idx,
                      input logic [7:0] wd, output logic [7:0] rv);
        int n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= {24'h000000, wd};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rv = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            $display("mismatch ack expected 1 seen 0");
        end
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] x;
        wb(1'b1, idx, d, x);
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [7:0] e);
        logic [7:0] x;
        wb(1'b0, idx, 8'h00, x);
        chk8($sformatf("reg_%h", idx), e, x);
    endtask : rd

    initial begin
        tick(5000);
        bad_count++;
        finish_test();
    end

    initial begin
        tick(6);
        rst <= 1'b0;
        tick(1);
        rd(6'h08, 8'h00);
        rd(6'h09, 8'h01);
        rd(6'h0a, 8'h00);
        rd(6'h3f, 8'h00);
        gpio <= 8'ha5;
        tick(1);
        gpio <= 8'h00;
        tick(1);
        rd(6'h08, 8'ha5);
        wr(6'h08, 8'h0f);
        rd(6'h08, 8'ha0);
        wr(6'h08, 8'h00);
        rd(6'h08, 8'ha0);
        wr(6'h09, 8'h01);
        rd(6'h09, 8'h00);
        for (int i = 1; i < 8; i++) begin
            peri[i] <= 1'b1;
            tick(1);
            peri[i] <= 1'b0;
            tick(1);
            rd(6'h09, 8'h01 << i);
            wr(6'h09, 8'hff);
        end
        prn_ack_n <= 1'b1;
        tick(1);
        prn_ack_n <= 1'b0;
        tick(1);
        rd(6'h09, 8'h01);
        wr(6'h09, 8'hff);
        par_act <= 1'b0;
        tick(1);
        par_act <= 1'b1;
        tick(1);
        rd(6'h09, 8'h01);
        wr(6'h09, 8'hff);
        wr(6'h0a, 8'h55);
        for (int j = 0; j < 3; j++) begin
            rsts <= 3'h1 << j;
            tick(1);
        end
        rsts <= 3'h0;
        tick(1);
        rd(6'h09, 8'h01);
        rd(6'h08, 8'ha0);
        rd(6'h0a, 8'h55);
        // Gpio bit 7 is set and now enabled; the global enable gates it.
        wr(6'h11, 8'h80);
        tick(2);
        chk1("wake_out_n", 1'b1, wake_n);
        chk1("wake_irq", 1'b1, irq);
        glob <= 1'b1;
        tick(2);
        chk1("wake_out_n", 1'b0, wake_n);
        glob <= 1'b0;
        tick(2);
        chk1("wake_out_n", 1'b1, wake_n);
        glob <= 1'b1;
        tick(2);
        wr(6'h11, 8'h00);
        tick(2);
        chk1("wake_out_n", 1'b1, wake_n);
        chk1("wake_irq", 1'b0, irq);
        wr(6'h11, 8'h80);
        wr(6'h08, 8'h80);
        tick(2);
        chk1("wake_out_n", 1'b1, wake_n);
        chk1("wake_irq", 1'b0, irq);
        rd(6'h08, 8'h20);
        for (int k = 0; k < 7; k++) begin
            misc[k] <= 1'b1;
            tick(1);
            misc[k] <= 1'b0;
            tick(1);
            rd(6'h10, 8'h01 << k);
            wr(6'h0a, 8'h01 << k);
            tick(2);
            chk1("wake_out_n", 1'b0, wake_n);
            wr(6'h10, 8'hff);
            tick(2);
            chk1("wake_out_n", 1'b1, wake_n);
        end
        chk8("wake_count", 8'h0a, wakes);
        wr(6'h12, 8'h01);
        tick(2);
        chk1("wake_out_n", 1'b0, wake_n);
        rd(6'h12, 8'h01);
        rd(6'h11, 8'h80);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        rd(6'h08, 8'h00);
        rd(6'h0a, 8'h00);
        rd(6'h09, 8'h01);
        rd(6'h12, 8'h00);
        chk1("wake_out_n", 1'b1, wake_n);
        finish_test();
    end
endmodule : wse_top_tb
